// ===== ril_pkg.sv
// shared constants and types for the radio interrupt logic
package ril_pkg;
   localparam int          RIL_AW            = 6;        // register address width
   localparam int          RIL_DW            = 8;        // register data width
   localparam logic [5:0]  RIL_ADDR_CTRL_ONE = 6'h04;    // transceiver_control_one
   localparam logic [5:0]  RIL_ADDR_ENABLE   = 6'h0E;    // interrupt_enable
   localparam logic [5:0]  RIL_ADDR_PENDING  = 6'h0F;    // interrupt_pending
   localparam logic [7:0]  RIL_CTRL_RESET    = 8'h20;    // checksum bit set
   localparam logic [7:0]  RIL_ENABLE_RESET  = 8'h00;    // all sources off
   localparam logic [7:0]  RIL_PENDING_RESET = 8'h00;    // nothing pending
   // control register bit positions
   localparam int          RIL_BIT_POLARITY  = 0;        // pin polarity
   localparam int          RIL_BIT_POLL_MODE = 1;        // polling mode
   localparam int          RIL_BIT_RXPIN_EN  = 6;        // rx start pin enable
   localparam int          RIL_BIT_CMD_LO    = 2;        // command mode low bit
   localparam int          RIL_BIT_CMD_HI    = 3;        // command mode high bit
   localparam int          RIL_BIT_RX_BL     = 4;        // rx buffer control bit
   localparam int          RIL_BIT_AUTO_CRC  = 5;        // automatic checksum bit
   localparam int          RIL_BIT_PA_EXT    = 7;        // external amplifier bit
   // event bit positions
   localparam int          RIL_EV_PLL_LOCK   = 0;        // pll lock
   localparam int          RIL_EV_PLL_UNLOCK = 1;        // pll unlock
   localparam int          RIL_EV_RX_START   = 2;        // reception start
   localparam int          RIL_EV_UNDERRUN   = 6;        // buffer underrun
   localparam int          RIL_EV_BATTERY_LOW_EVENT    = 7;        // battery low

   // register access request from the serial host port
   typedef struct packed {
      logic              wr;         // write strobe
      logic              rd;         // read strobe
      logic [5:0]        addr;       // register address
      logic [7:0]        wdata;      // write data
   } ril_req_type;

   // state of the whole block
   typedef struct packed {
      logic [7:0]        ctrl;       // transceiver_control_one
      logic [7:0]        enable;     // interrupt_enable
      logic [7:0]        pending;    // interrupt_pending
      logic [7:0]        rdata;      // read data holding register
      logic              rvalid;     // read data valid pulse
      logic              rx_pin;     // rx start pin state
   } ril_state_type;
endpackage

// ===== ril_top.sv
// interrupt logic: pending, enable, control registers and pins
// What this block does
// - enable bit one enables its source
// - enable register resets to zero
// - enable register at 0x0E, fixed bit order
// - pending register 0x0F, read-only, resets zero
// - reading pending clears all flags not re-set in that cycle, pin
// - normal mode latches only enabled events
// - polling mode latches all, pin enabled
// - polling mode is control bit 1
// - masked polled events never assert pin
// - control bit 0 selects pin polarity
// - buffer empty indication always active high
// - control bit 6 drives rx start pin
// - rx start pin ignores enable bit
// - rx start pin high until frame ends
// - control resets 0x20, bits 3:2 command mode
// - pending enabled events ORed onto pin
// - flags sticky; pll lock/unlock clear each other
`timescale 1ns/1ps
module ril_top
   import ril_pkg::*;
(
   input  wire logic               CLK_SYS,        // 100 MHz master clock
   input  wire logic               RESETN,         // async reset, active low
   input  wire ril_pkg::ril_req_type REQ,          // register access request
   output logic [7:0]              RDATA,          // read data, registered
   output logic                    RVALID,         // read data valid pulse
   input  wire logic [7:0]         EVENTS,         // one-cycle event pulses
   input  wire logic               FRAME_ACTIVE,   // high during frame receive
   input  wire logic               FBE_ACTIVE,     // buffer empty indicator on
   input  wire logic               FBE_LEVEL,      // buffer empty level
   output logic                    IRQ_PIN,        // interrupt output pin
   output logic                    RX_START_PIN,   // rx start output pin
   output logic [1:0]              CMD_MODE,       // serial command mode field
   output logic                    AUTO_CRC,       // automatic checksum enable
   output logic                    EXT_PA_EN,      // control bit 7
   output logic                    RX_BL_CTRL      // control bit 4
);
   import ril_pkg::*;

   ril_state_type st_r;          // registered state
   ril_state_type st_nxt;        // next state
   logic [7:0]    latch_ev;      // events allowed into pending
   logic          rd_pend;       // read of pending this cycle
   logic          irq_active;    // interrupt active before polarity
   logic          rx_pin_q;      // registered rx pin copy for the pin

   // next-state logic for all registers
   always_comb begin
      st_nxt = st_r;
      // latch_ev and rd_pend get a value on every path, so no latches form
      st_nxt.rvalid = 1'b0;
      rd_pend = REQ.rd && (REQ.addr == RIL_ADDR_PENDING);
      // polling mode lets every event in, else only enabled ones
      if (st_r.ctrl[RIL_BIT_POLL_MODE]) begin
         latch_ev = EVENTS;
      end else begin
         latch_ev = EVENTS & st_r.enable;
      end
      // read clears everything; new events are merged after so they win
      if (rd_pend) begin
         st_nxt.pending = RIL_PENDING_RESET;
      end
      // lock and unlock knock each other out when newly set
      if (latch_ev[RIL_EV_PLL_LOCK]) begin
         st_nxt.pending[RIL_EV_PLL_UNLOCK] = 1'b0;
      end
      if (latch_ev[RIL_EV_PLL_UNLOCK]) begin
         st_nxt.pending[RIL_EV_PLL_LOCK] = 1'b0;
      end
      st_nxt.pending = st_nxt.pending | latch_ev;
      // register writes; pending is read-only
      if (REQ.wr) begin
         case (REQ.addr)
            RIL_ADDR_CTRL_ONE: st_nxt.ctrl = REQ.wdata;
            RIL_ADDR_ENABLE:   st_nxt.enable = REQ.wdata;
            default: ;
         endcase
      end
      // register reads return data one cycle later
      if (REQ.rd) begin
         st_nxt.rvalid = 1'b1;
         case (REQ.addr)
            RIL_ADDR_CTRL_ONE: st_nxt.rdata = st_r.ctrl;
            RIL_ADDR_ENABLE:   st_nxt.rdata = st_r.enable;
            RIL_ADDR_PENDING:  st_nxt.rdata = st_r.pending;
            default:           st_nxt.rdata = 8'h00;
         endcase
      end
      // rx start pin: set on header, held until frame ends
      // the enable register is not consulted: the pin runs unmasked
      if (!st_r.ctrl[RIL_BIT_RXPIN_EN] || !FRAME_ACTIVE) begin
         st_nxt.rx_pin = 1'b0;
      end else if (EVENTS[RIL_EV_RX_START]) begin
         st_nxt.rx_pin = 1'b1;
      end
   end

   // state register
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         st_r.ctrl    <= RIL_CTRL_RESET;
         st_r.enable  <= RIL_ENABLE_RESET;
         st_r.pending <= RIL_PENDING_RESET;
         st_r.rdata   <= 8'h00;
         st_r.rvalid  <= 1'b0;
         st_r.rx_pin  <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // pending and enabled flags merged; masked polled flags never reach it
   assign irq_active = |(st_r.pending & st_r.enable);

   // pin: buffer empty indicator bypasses the polarity choice
   // combinational so the pin drops in the cycle after a clearing read
   always_comb begin
      if (FBE_ACTIVE) begin
         IRQ_PIN = FBE_LEVEL;
      end else begin
         IRQ_PIN = irq_active ^ st_r.ctrl[RIL_BIT_POLARITY];
      end
   end

   assign rx_pin_q     = st_r.rx_pin;
   assign RX_START_PIN = rx_pin_q;
   assign RDATA        = st_r.rdata;
   assign RVALID       = st_r.rvalid;
   // remaining control bits are only stored here and passed out
   assign CMD_MODE     = st_r.ctrl[RIL_BIT_CMD_HI:RIL_BIT_CMD_LO];
   assign AUTO_CRC     = st_r.ctrl[RIL_BIT_AUTO_CRC];
   assign EXT_PA_EN    = st_r.ctrl[RIL_BIT_PA_EXT];
   assign RX_BL_CTRL   = st_r.ctrl[RIL_BIT_RX_BL];

   // checks on the registers, the interrupt pin and the rx start pin

   // a read clears every flag not re-set in that same cycle
   property p_read_clears;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (REQ.rd && REQ.addr == RIL_ADDR_PENDING && EVENTS == 8'h00)
         |=> (st_r.pending == 8'h00);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("pending not cleared by read");

   // an event in the read cycle survives
   property p_event_survives;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (rd_pend && latch_ev[RIL_EV_BATTERY_LOW_EVENT]) |=>
         st_r.pending[RIL_EV_BATTERY_LOW_EVENT];
   endproperty
   a_event_survives: assert property (p_event_survives)
      else $error("event lost during read");

   // normal mode: masked events never latch
   property p_masked_ignored;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (!st_r.ctrl[RIL_BIT_POLL_MODE] && !st_r.enable[RIL_EV_BATTERY_LOW_EVENT]
       && !rd_pend && !st_r.pending[RIL_EV_BATTERY_LOW_EVENT])
         |=> !st_r.pending[RIL_EV_BATTERY_LOW_EVENT];
   endproperty
   a_masked_ignored: assert property (p_masked_ignored)
      else $error("masked event latched");

   // polling mode: an underrun event latches whatever its enable bit
   property p_poll_latch;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (st_r.ctrl[RIL_BIT_POLL_MODE] && EVENTS[RIL_EV_UNDERRUN])
         |=> st_r.pending[RIL_EV_UNDERRUN];
   endproperty
   a_poll_latch: assert property (p_poll_latch)
      else $error("polled event not latched");

   // any enabled event shows on the pin next cycle, unless fbe owns it
   property p_enabled_pin;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (|(EVENTS & st_r.enable) && !REQ.wr)
         |=> (FBE_ACTIVE || IRQ_PIN == !st_r.ctrl[RIL_BIT_POLARITY]);
   endproperty
   a_enabled_pin: assert property (p_enabled_pin)
      else $error("enabled event missing on pin");

   // zero enable keeps the pin idle
   property p_zero_enable_idle;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (st_r.enable == 8'h00 && !FBE_ACTIVE)
         |-> (IRQ_PIN == st_r.ctrl[RIL_BIT_POLARITY]);
   endproperty
   a_zero_enable_idle: assert property (p_zero_enable_idle)
      else $error("pin active with nothing enabled");

   // lock clears unlock
   property p_lock_exclusive;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (latch_ev[RIL_EV_PLL_LOCK] && !latch_ev[RIL_EV_PLL_UNLOCK])
         |=> (st_r.pending[RIL_EV_PLL_LOCK]
              && !st_r.pending[RIL_EV_PLL_UNLOCK]);
   endproperty
   a_lock_exclusive: assert property (p_lock_exclusive)
      else $error("lock did not clear unlock");

   // rx pin follows header even when disabled in enable register
   sequence s_header;
      st_r.ctrl[RIL_BIT_RXPIN_EN] && FRAME_ACTIVE && EVENTS[RIL_EV_RX_START]
         && !REQ.wr;
   endsequence
   property p_rx_pin_set;
      @(posedge CLK_SYS) disable iff (!RESETN)
      s_header |=> RX_START_PIN;
   endproperty
   a_rx_pin_set: assert property (p_rx_pin_set)
      else $error("rx start pin not raised");

   // rx pin drops once the frame ends
   property p_rx_pin_hold;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (RX_START_PIN && !FRAME_ACTIVE) |=> !RX_START_PIN;
   endproperty
   a_rx_pin_hold: assert property (p_rx_pin_hold)
      else $error("rx start pin held after frame");

   // writes to the pending register change nothing
   property p_pending_read_only;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (REQ.wr && REQ.addr == RIL_ADDR_PENDING && !rd_pend
       && EVENTS == 8'h00) |=> (st_r.pending == $past(st_r.pending));
   endproperty
   a_pending_read_only: assert property (p_pending_read_only)
      else $error("write altered pending register");

   // enable register takes the written byte
   property p_enable_write;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (REQ.wr && REQ.addr == RIL_ADDR_ENABLE)
         |=> (st_r.enable == $past(REQ.wdata));
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable register write lost");

   // control register takes the written byte
   property p_ctrl_write;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (REQ.wr && REQ.addr == RIL_ADDR_CTRL_ONE)
         |=> (st_r.ctrl == $past(REQ.wdata));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control register write lost");

   // a pending read answers next cycle with the flags as they stood
   sequence s_pending_read;
      rd_pend;
   endsequence
   property p_read_answer;
      @(posedge CLK_SYS) disable iff (!RESETN)
      s_pending_read |=> (RVALID && RDATA == $past(st_r.pending));
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("pending read answered wrongly");

   // unlock clears lock
   property p_unlock_exclusive;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (latch_ev[RIL_EV_PLL_UNLOCK] && !latch_ev[RIL_EV_PLL_LOCK])
         |=> (st_r.pending[RIL_EV_PLL_UNLOCK]
              && !st_r.pending[RIL_EV_PLL_LOCK]);
   endproperty
   a_unlock_exclusive: assert property (p_unlock_exclusive)
      else $error("unlock did not clear lock");

   // a clearing read with no new event releases the pin
   property p_read_releases_pin;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (rd_pend && latch_ev == 8'h00 && !REQ.wr)
         |=> (FBE_ACTIVE || IRQ_PIN == st_r.ctrl[RIL_BIT_POLARITY]);
   endproperty
   a_read_releases_pin: assert property (p_read_releases_pin)
      else $error("pin still active after read");

   // buffer empty indication owns the pin whatever the polarity
   property p_fbe_override;
      @(posedge CLK_SYS) disable iff (!RESETN)
      FBE_ACTIVE |-> (IRQ_PIN == FBE_LEVEL);
   endproperty
   a_fbe_override: assert property (p_fbe_override)
      else $error("buffer empty level not on pin");

   // rx start pin stays low while its enable bit is clear
   property p_rx_pin_gated;
      @(posedge CLK_SYS) disable iff (!RESETN)
      !st_r.ctrl[RIL_BIT_RXPIN_EN] |=> !RX_START_PIN;
   endproperty
   a_rx_pin_gated: assert property (p_rx_pin_gated)
      else $error("rx start pin high while disabled");

   // a flag stays set until a pending read
   property p_flag_sticky;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (st_r.pending[RIL_EV_BATTERY_LOW_EVENT] && !rd_pend)
         |=> st_r.pending[RIL_EV_BATTERY_LOW_EVENT];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("pending flag dropped without read");
endmodule

// ===== ril_host.sv
// host model issuing register requests to the interrupt logic
`timescale 1ns/1ps
module ril_host
   import ril_pkg::*;
(
   input  wire logic            clk_sys, // master clock
   output ril_pkg::ril_req_type req,     // request to the block
   input  wire logic [7:0]      rdata,   // read data from the block
   input  wire logic            rvalid   // read data valid pulse
);
   // idle bus shows the inverse of its last address; wdata is inverted only after a write
   initial req = '{wr: 1'b0, rd: 1'b0, addr: 6'h2A, wdata: 8'h55};

   // write: call at a falling edge; taken at the next rising edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk_sys);
      req.wr = 1'b0;
      req.addr = ~a;
      req.wdata = ~d;
      @(negedge clk_sys); // a free edge so strobes never retoggle
   endtask

   // read: answer is sampled one cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [7:0] d,
                     output logic v);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk_sys);
      d = rdata;
      v = rvalid;
      req.rd = 1'b0;
      req.addr = ~a;
      @(negedge clk_sys);
   endtask
endmodule

// ===== tb_radio_interrupt_logic.sv
// self-checking bench for the radio interrupt logic
`timescale 1ns/1ps
module tb_radio_interrupt_logic;
   import ril_pkg::*;
   logic        clk_sys = 1'b0; // 100 MHz clock
   logic        resetn;         // reset, active low
   ril_req_type req;            // host request
   logic [7:0]  rdata;          // read data
   logic        rvalid;         // read valid
   logic [7:0]  events;         // event pulses
   logic        frame_active;   // frame receive level
   logic        fbe_active;     // buffer empty owns pin
   logic        fbe_level;      // buffer empty level
   logic        irq_pin;        // interrupt pin
   logic        rx_pin;         // rx start pin
   logic [1:0]  cmd_mode;       // command mode field
   logic        auto_crc;       // checksum bit
   logic        ext_pa_en;      // control bit 7
   logic        rx_bl_ctrl;     // control bit 4
   int          failures = 0;   // mismatches
   int          n_tests = 0;    // comparisons

   always #5 clk_sys = ~clk_sys;

   ril_top DUT (.CLK_SYS(clk_sys), .RESETN(resetn), .REQ(req),
      .RDATA(rdata), .RVALID(rvalid), .EVENTS(events),
      .FRAME_ACTIVE(frame_active), .FBE_ACTIVE(fbe_active),
      .FBE_LEVEL(fbe_level), .IRQ_PIN(irq_pin), .RX_START_PIN(rx_pin),
      .CMD_MODE(cmd_mode), .AUTO_CRC(auto_crc), .EXT_PA_EN(ext_pa_en),
      .RX_BL_CTRL(rx_bl_ctrl));
   ril_host host (.clk_sys(clk_sys), .req(req), .rdata(rdata),
      .rvalid(rvalid));

   // verdict and end of run
   task automatic results;
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // compare seen against expected
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // read a register and check both data and valid pulse
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      host.rd(a, d, v);
      chk(d, exp);
      chk({7'h00, v}, 8'h01);
   endtask

   // one-cycle event pulse; pin is settled on return
   task automatic ev(input logic [7:0] e);
      events = e;
      @(negedge clk_sys);
      events = 8'h00;
      @(negedge clk_sys); // quiet edge so back-to-back pulses stay apart
   endtask

   // hang guard: a bounded run counts as a mismatch if it expires
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      results;
   end

   // main sequence, inputs change on falling edges only
   initial begin
      resetn = 1'b0;
      events = 8'h00;
      frame_active = 1'b0;
      fbe_active = 1'b0;
      fbe_level = 1'b0;
      repeat (6) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      rdc(RIL_ADDR_CTRL_ONE, RIL_CTRL_RESET);
      rdc(RIL_ADDR_ENABLE, 8'h00);
      rdc(RIL_ADDR_PENDING, 8'h00);
      chk({5'h00, auto_crc, cmd_mode}, 8'h04);
      rdc(6'h3F, 8'h00);
      ev(8'hFF);
      chk({7'h00, irq_pin}, 8'h00);
      rdc(RIL_ADDR_PENDING, 8'h00);
      host.wr(RIL_ADDR_ENABLE, 8'h08);
      rdc(RIL_ADDR_ENABLE, 8'h08);
      host.wr(RIL_ADDR_PENDING, 8'hFF);
      rdc(RIL_ADDR_PENDING, 8'h00);
      ev(8'h04);
      chk({7'h00, irq_pin}, 8'h00);
      ev(8'h08);
      chk({7'h00, irq_pin}, 8'h01);
      rdc(RIL_ADDR_PENDING, 8'h08);
      chk({7'h00, irq_pin}, 8'h00);
      host.wr(RIL_ADDR_ENABLE, 8'h03);
      ev(8'h01);
      ev(8'h02);
      rdc(RIL_ADDR_PENDING, 8'h02);
      // polling mode with everything masked
      host.wr(RIL_ADDR_CTRL_ONE, 8'h22);
      host.wr(RIL_ADDR_ENABLE, 8'h00);
      ev(8'hF0);
      chk({7'h00, irq_pin}, 8'h00);
      rdc(RIL_ADDR_CTRL_ONE, 8'h22);
      rdc(RIL_ADDR_PENDING, 8'hF0);
      // active-low pin, event landing on the clearing read
      host.wr(RIL_ADDR_CTRL_ONE, 8'h21);
      chk({7'h00, irq_pin}, 8'h01);
      host.wr(RIL_ADDR_ENABLE, 8'h80);
      fork
         rdc(RIL_ADDR_PENDING, 8'h00);
         ev(8'h80);
      join
      chk({7'h00, irq_pin}, 8'h00);
      fbe_active = 1'b1;
      fbe_level = 1'b1;
      @(negedge clk_sys);
      chk({7'h00, irq_pin}, 8'h01);
      fbe_active = 1'b0;
      rdc(RIL_ADDR_PENDING, 8'h80);
      host.wr(RIL_ADDR_CTRL_ONE, 8'h9C);
      chk({ext_pa_en, auto_crc, rx_bl_ctrl, cmd_mode, 3'h0}, 8'hB8);
      // rx start pin with control bit 6 set while its interrupt_enable bit stays clear
      host.wr(RIL_ADDR_CTRL_ONE, 8'h40);
      frame_active = 1'b1;
      ev(8'h04);
      chk({7'h00, rx_pin}, 8'h01);
      repeat (3) @(negedge clk_sys);
      chk({7'h00, rx_pin}, 8'h01);
      frame_active = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk({7'h00, rx_pin}, 8'h00);
      // second reset in mid-run brings the registers back to defaults
      host.wr(RIL_ADDR_ENABLE, 8'h5A);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      rdc(RIL_ADDR_ENABLE, RIL_ENABLE_RESET);
      rdc(RIL_ADDR_CTRL_ONE, RIL_CTRL_RESET);
      results;
   end
endmodule
